// ### dv/clp_config_latch_port_assertions.sv
`timescale 1ns/100ps
module clp_config_latch_port_assertions
    import clp_pkg::*;
(
    input wire logic                       clk_i,
    input wire logic                       rst_n_i,
    input wire logic [CLP_ADDR_W-1:0]      config_addr_i,
    input wire logic [CLP_DATA_W-1:0]      config_data_i,
    input wire logic                       config_write_strobe_i,
    input wire logic [CLP_DATA_W-1:0]      rd_data_o,
    input wire logic [CLP_NUM_CH-1:0]      channel_reference_clock_i,
    input wire logic [CLP_NUM_CH-1:0]      tx_parallel_input_clock_i,
    input wire logic [CLP_NUM_CH-1:0][1:0] signaling_range_select_i,
    input wire logic [CLP_NUM_CH-1:0]      tx_clock_out_o,
    input wire logic [CLP_NUM_CH-1:0]      char_tick_o,
    input wire logic [CLP_NUM_CH-1:0]      char_sample_o,
    input wire logic [CLP_NUM_CH-1:0][1:0] pll_range_o,
    input wire logic [CLP_NUM_CH-1:0]      tx_pll_rate_select_o,
    input wire logic [CLP_NUM_CH-1:0]      tx_input_clock_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr_ch0;
        (config_write_strobe_i && config_addr_i == CLP_ADDR_CH0) [*4];
    endsequence
    sequence s_wr_unmapped;
        (config_write_strobe_i && config_addr_i > CLP_ADDR_CHLAST) [*4];
    endsequence
    // a stale high output after a rate change would hide the rise, so start from low
    sequence s_rise_single;
        !tx_pll_rate_select_o[0] && !tx_clock_out_o[0] && $rose(channel_reference_clock_i[0]);
    endsequence
    sequence s_rise_double;
        tx_pll_rate_select_o[0] && $rose(channel_reference_clock_i[0]);
    endsequence
    a_reset_values: assert property (disable iff (1'b0) !rst_n_i |=>
        (tx_input_clock_select_o == '1 && tx_pll_rate_select_o == '0 && rd_data_o == '0
         && tx_clock_out_o == '0 && pll_range_o[0] == CLP_RANGE_MID))
        else $error("reset values wrong");
    a_range_map: assert property ($stable(signaling_range_select_i[0]) [*5] |->
        pll_range_o[0] == (signaling_range_select_i[0] == CLP_SPD_LOW ? CLP_RANGE_LOW :
        signaling_range_select_i[0] == CLP_SPD_HIGH ? CLP_RANGE_HIGH : CLP_RANGE_MID))
        else $error("range output does not follow speed pin");
    a_tick_follows: assert property ($rose(tx_clock_out_o[0]) |->
        ##[0:1] (char_tick_o[0] ##1 !char_tick_o[0])) else $error("character tick missing");
    a_rate_single: assert property (s_rise_single |-> ##[1:5] $rose(tx_clock_out_o[0]))
        else $error("tx clock misses reference edge");
    // a rate drop part way through a half period ends the doubled pattern early
    a_rate_double: assert property (s_rise_double |->
        (##[1:5] $changed(tx_clock_out_o[0]) ##[2:6] $changed(tx_clock_out_o[0]))
        or (##[1:9] !tx_pll_rate_select_o[0]))
        else $error("tx clock not doubled");
    a_ext_idle: assert property ((!tx_input_clock_select_o[0] &&
        !tx_parallel_input_clock_i[0]) [*8] |-> !char_sample_o[0])
        else $error("sample without external clock edge");
    a_unmapped_keep: assert property (s_wr_unmapped |->
        ($stable(tx_input_clock_select_o) && $stable(tx_pll_rate_select_o)) [*4])
        else $error("unmapped write changed a latch");
    a_write_lands: assert property (s_wr_ch0 |-> ##[0:2]
        (tx_input_clock_select_o[0] == config_data_i[CLP_F_CKSEL]
         && tx_pll_rate_select_o[0] == config_data_i[CLP_F_RATE]))
        else $error("write did not reach latch");
endmodule : clp_config_latch_port_assertions

bind clp_config_latch_port clp_config_latch_port_assertions u_chk (.clk_i, .rst_n_i,
    .config_addr_i, .config_data_i, .config_write_strobe_i, .rd_data_o,
    .channel_reference_clock_i, .tx_parallel_input_clock_i, .signaling_range_select_i,
    .tx_clock_out_o, .char_tick_o, .char_sample_o, .pll_range_o, .tx_pll_rate_select_o,
    .tx_input_clock_select_o);

// ### dv/clp_host_model.sv
`timescale 1ns/100ps
module clp_host_model
    import clp_pkg::*;
(
    input  wire logic  clk_i,
    output clp_cfg_wr_s cfg_o
);
    initial cfg_o = '0;
    task automatic write_latch(input logic [CLP_ADDR_W-1:0] addr,
                               input logic [CLP_DATA_W-1:0] data);
        @(posedge clk_i);
        cfg_o.addr <= addr;
        cfg_o.data <= data;
        repeat (2) @(posedge clk_i);
        cfg_o.strobe <= 1'b1;
        // the strobe is async, so it must outlast the two sync flops
        repeat (4) @(posedge clk_i);
        cfg_o.strobe <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : write_latch
endmodule : clp_host_model

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench
    import clp_pkg::*;
;
    logic clk_i, rst_n_i, rd_s, rd_pend;
    logic [3:0] rd_a, ref_c, txp_c, tx_o, tick, smp, lch, rsel, csel;
    logic [4:0] rd_d;
    logic [3:0][1:0] spd, rng;
    logic [7:0] tcnt;
    logic [31:0] lfsr;
    logic [2:0] cfg_exp [4];
    logic [4:0] exp_q [$];
    clp_cfg_wr_s cfg;
    int fails, cmp_count, cyc, tk[4], ln[4], sm[4];
    clp_host_model host (.clk_i(clk_i), .cfg_o(cfg));
    clp_config_latch_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .config_addr_i(cfg.addr), .config_data_i(cfg.data), .config_write_strobe_i(cfg.strobe),
        .rd_strobe_i(rd_s), .rd_addr_i(rd_a), .rd_data_o(rd_d),
        .channel_reference_clock_i(ref_c), .tx_parallel_input_clock_i(txp_c),
        .signaling_range_select_i(spd), .tx_clock_out_o(tx_o), .char_tick_o(tick),
        .char_sample_o(smp), .char_launch_o(lch), .pll_range_o(rng),
        .tx_pll_rate_select_o(rsel), .tx_input_clock_select_o(csel));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [1:0] exp_rng(input logic [1:0] c);
        return c == CLP_SPD_LOW  ? CLP_RANGE_LOW  :
               c == CLP_SPD_HIGH ? CLP_RANGE_HIGH : CLP_RANGE_MID;
    endfunction : exp_rng
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic check_rd(input logic [4:0] e, input logic [4:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value rd_data_o expected %h seen %h", e, s);
        end
    endtask : check_rd
    task automatic check_val(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", n, e, s);
        end
    endtask : check_val
    task automatic read_all();
        for (int a = 0; a < 16; a++) begin
            rd_s <= 1'b1;
            rd_a <= 4'(a);
            exp_q.push_back(a < 4 ? {exp_rng(spd[a]), cfg_exp[a]} : 5'h00);
            @(posedge clk_i);
        end
        rd_s <= 1'b0;
    endtask : read_all
    task automatic measure();
        for (int i = 0; i < 4; i++) begin
            tk[i] = 0;
            ln[i] = 0;
            sm[i] = 0;
        end
        repeat (64) @(posedge clk_i);
    endtask : measure
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // one-cycle skew between channels: no fixed phase is assumed anywhere
    always @(posedge clk_i) begin
        tcnt <= tcnt + 8'h01;
        ref_c <= rst_n_i ? {ref_c[2:0], tcnt[3]} : 4'h0;
        txp_c <= {4{rst_n_i & tcnt[4]}};
        rd_pend <= rd_s;
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            fails++;
            end_sim();
        end
    end
    always @(negedge clk_i) begin
        if (rd_pend === 1'b1) check_rd(exp_q.pop_front(), rd_d);
        for (int i = 0; i < 4; i++) begin
            tk[i] += int'(tick[i] === 1'b1);
            ln[i] += int'(lch[i] === 1'b1);
            sm[i] += int'(smp[i] === 1'b1);
        end
    end
    initial begin
        logic k, r, h;
        logic [7:0] es;
        rst_n_i = 1'b0;
        {rd_s, rd_pend, rd_a, tcnt, ref_c, txp_c, cyc, fails, cmp_count} = '0;
        lfsr = 32'h1413EBD0;
        spd = lfsr[7:0];
        cfg_exp = '{4{3'h1}};
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // the speed pins need their sync flops and decode before readback is valid
        repeat (4) @(posedge clk_i);
        read_all();
        $display("reset test done");
        for (int p = 0; p < 4; p++) begin
            lfsr = lfsr_next(lfsr);
            spd <= lfsr[7:0];
            host.write_latch(4'h4 + {1'b0, lfsr[10:8]}, lfsr[20:16]);
            for (int c = 0; c < 4; c++) begin
                {k, r, h} = {p != 3, 1'((c + p) % 2), 1'((c + p) / 2 % 2)};
                cfg_exp[c] = {h, r, k};
                host.write_latch(4'(c), {lfsr[2 * c + 12 +: 2], h, r, k});
            end
            repeat (48) @(posedge clk_i);
            measure();
            for (int c = 0; c < 4; c++) begin
                check_val("tick", cfg_exp[c][1] ? 8'h08 : 8'h04, 8'(tk[c]));
                check_val("launch", cfg_exp[c][2] ? 8'h08 : 8'h04, 8'(ln[c]));
                es = cfg_exp[c][0] ? (cfg_exp[c][2] ? 8'h08 : 8'h04) : 8'h02;
                check_val("sample", es, 8'(sm[c]));
                check_val("rate sel", {7'h00, cfg_exp[c][1]}, {7'h00, rsel[c]});
                check_val("clock sel", {7'h00, cfg_exp[c][0]}, {7'h00, csel[c]});
                check_val("range", {6'h00, exp_rng(spd[c])}, {6'h00, rng[c]});
            end
            read_all();
            $display("test phase %0d done", p);
        end
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule : testbench

// ### hdl/clp_config_latch_port.sv
// How it works
// - tx clock output tracks the character clock
// - rate 0 gives reference frequency, 1 doubles
// - no fixed phase to reference clock
// - reset loads every latch and counter defaults
// - ternary speed pin picks PLL rate range
// - write strobe stores data at addressed latch
// - half-rate samples inputs on both reference edges when clock select is 1
// - half-rate launches outputs on both reference edges
// - rate select lives in a configuration latch
// - clock select 0 uses external input clock
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module clp_config_latch_port
    import clp_pkg::*;
(
    input  wire logic                             clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             ce_i,
    input  wire logic [CLP_ADDR_W-1:0]            config_addr_i,
    input  wire logic [CLP_DATA_W-1:0]            config_data_i,
    input  wire logic                             config_write_strobe_i,
    input  wire logic                             rd_strobe_i,
    input  wire logic [CLP_ADDR_W-1:0]            rd_addr_i,
    output logic      [CLP_DATA_W-1:0]            rd_data_o,
    input  wire logic [CLP_NUM_CH-1:0]            channel_reference_clock_i,
    input  wire logic [CLP_NUM_CH-1:0]            tx_parallel_input_clock_i,
    input  wire logic [CLP_NUM_CH-1:0][1:0]       signaling_range_select_i,
    output logic      [CLP_NUM_CH-1:0]            tx_clock_out_o,
    output logic      [CLP_NUM_CH-1:0]            char_tick_o,
    output logic      [CLP_NUM_CH-1:0]            char_sample_o,
    output logic      [CLP_NUM_CH-1:0]            char_launch_o,
    output logic      [CLP_NUM_CH-1:0][1:0]       pll_range_o,
    output logic      [CLP_NUM_CH-1:0]            tx_pll_rate_select_o,
    output logic      [CLP_NUM_CH-1:0]            tx_input_clock_select_o
);

    clp_cfg_wr_s                     wr_meta_reg;
    clp_cfg_wr_s                     wr_sync_reg;
    logic                            wr_last_reg;
    logic                            wr_fire;
    logic [CLP_NUM_CH-1:0]           ref_meta_reg;
    logic [CLP_NUM_CH-1:0]           ref_sync_reg;
    logic [CLP_NUM_CH-1:0]           ref_last_reg;
    logic [CLP_NUM_CH-1:0]           txin_meta_reg;
    logic [CLP_NUM_CH-1:0]           txin_sync_reg;
    logic [CLP_NUM_CH-1:0]           txin_last_reg;
    logic [CLP_NUM_CH-1:0][1:0]      spd_meta_reg;
    logic [CLP_NUM_CH-1:0][1:0]      spd_sync_reg;
    clp_chan_cfg_s [CLP_NUM_CH-1:0]  cfg_reg;
    clp_range_e [CLP_NUM_CH-1:0]     range_reg;
    logic [CLP_NUM_CH-1:0]           ref_rise;
    logic [CLP_NUM_CH-1:0]           ref_fall;
    logic [CLP_NUM_CH-1:0]           sample_next;
    logic [CLP_NUM_CH-1:0]           launch_next;
    logic [CLP_NUM_CH-1:0]           tick_w;
    logic [CLP_NUM_CH-1:0]           txclk_w;

    // write, reference, tx input and speed pins are asynchronous, so two flops before any use; the read port is used directly
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_meta_reg <= '0;
            wr_sync_reg <= '0;
            wr_last_reg <= 1'b0;
        end else if (ce_i) begin
            wr_meta_reg <= '{addr: config_addr_i,
                             data: config_data_i,
                             strobe: config_write_strobe_i};
            wr_sync_reg <= wr_meta_reg;
            wr_last_reg <= wr_sync_reg.strobe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ref_meta_reg  <= '0;
            ref_sync_reg  <= '0;
            ref_last_reg  <= '0;
            txin_meta_reg <= '0;
            txin_sync_reg <= '0;
            txin_last_reg <= '0;
            spd_meta_reg  <= '0;
            spd_sync_reg  <= '0;
        end else if (ce_i) begin
            ref_meta_reg  <= channel_reference_clock_i;
            ref_sync_reg  <= ref_meta_reg;
            ref_last_reg  <= ref_sync_reg;
            txin_meta_reg <= tx_parallel_input_clock_i;
            txin_sync_reg <= txin_meta_reg;
            txin_last_reg <= txin_sync_reg;
            spd_meta_reg  <= signaling_range_select_i;
            spd_sync_reg  <= spd_meta_reg;
        end
    end

    // the strobe edge is taken after sync; address and data went through the
    // same two flops and must already be steady by then
    assign wr_fire = wr_sync_reg.strobe & ~wr_last_reg;

    // channel latches; an address outside the channel span writes nothing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= {CLP_NUM_CH{CLP_RST_CFG}};
        end else if (ce_i && wr_fire) begin
            for (int n = 0; n < CLP_NUM_CH; n++) begin
                if (wr_sync_reg.addr == CLP_ADDR_CH0 + 4'(n)
                    && wr_sync_reg.addr <= CLP_ADDR_CHLAST) begin
                    cfg_reg[n].cksel     <= wr_sync_reg.data[CLP_F_CKSEL];
                    cfg_reg[n].rate      <= wr_sync_reg.data[CLP_F_RATE];
                    cfg_reg[n].half_rate <= wr_sync_reg.data[CLP_F_HALF];
                end
            end
        end
    end

    // a floating pin code outside the three levels is read as mid
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int n = 0; n < CLP_NUM_CH; n++) begin
                range_reg[n] <= CLP_RANGE_MID;
            end
        end else if (ce_i) begin
            for (int n = 0; n < CLP_NUM_CH; n++) begin
                case (spd_sync_reg[n])
                    CLP_SPD_LOW:  range_reg[n] <= CLP_RANGE_LOW;
                    CLP_SPD_HIGH: range_reg[n] <= CLP_RANGE_HIGH;
                    default:      range_reg[n] <= CLP_RANGE_MID;
                endcase
            end
        end
    end

    assign ref_rise = ref_sync_reg & ~ref_last_reg;
    assign ref_fall = ~ref_sync_reg & ref_last_reg;

    always_comb begin
        for (int n = 0; n < CLP_NUM_CH; n++) begin
            launch_next[n] = ref_rise[n] | (cfg_reg[n].half_rate & ref_fall[n]);
            if (!cfg_reg[n].cksel) begin
                sample_next[n] = txin_sync_reg[n] & ~txin_last_reg[n];
            end else begin
                sample_next[n] = ref_rise[n]
                               | (cfg_reg[n].half_rate & ref_fall[n]);
            end
        end
    end

    generate
        for (genvar g = 0; g < CLP_NUM_CH; g++) begin : g_ch
            clp_txclk_gen u_gen (
                .clk_i       (clk_i),
                .rst_n_i     (rst_n_i),
                .ce_i        (ce_i),
                .ref_level_i (ref_sync_reg[g]),
                .ref_edge_i  (ref_rise[g] | ref_fall[g]),
                .rate_i      (cfg_reg[g].rate),
                .tx_clk_o    (txclk_w[g]),
                .char_tick_o (tick_w[g])
            );
        end
    endgenerate

    assign tx_clock_out_o = txclk_w;
    assign char_tick_o    = tick_w;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            char_sample_o <= '0;
            char_launch_o <= '0;
        end else if (ce_i) begin
            char_sample_o <= sample_next;
            char_launch_o <= launch_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pll_range_o             <= {CLP_NUM_CH{CLP_RANGE_MID}};
            tx_pll_rate_select_o    <= {CLP_NUM_CH{CLP_RST_RATE}};
            tx_input_clock_select_o <= {CLP_NUM_CH{CLP_RST_CKSEL}};
        end else if (ce_i) begin
            for (int n = 0; n < CLP_NUM_CH; n++) begin
                pll_range_o[n]             <= range_reg[n];
                tx_pll_rate_select_o[n]    <= cfg_reg[n].rate;
                tx_input_clock_select_o[n] <= cfg_reg[n].cksel;
            end
        end
    end

    // readback: latch fields plus the decoded range; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= CLP_RST_RDATA;
        end else if (ce_i) begin
            rd_data_o <= CLP_RST_RDATA;
            if (rd_strobe_i) begin
                for (int n = 0; n < CLP_NUM_CH; n++) begin
                    if (rd_addr_i == CLP_ADDR_CH0 + 4'(n)) begin
                        rd_data_o <= {range_reg[n], cfg_reg[n].half_rate,
                                      cfg_reg[n].rate, cfg_reg[n].cksel};
                    end
                end
            end
        end
    end

endmodule : clp_config_latch_port

// ### hdl/clp_pkg.sv
package clp_pkg;

    localparam int          CLP_NUM_CH      = 4;
    localparam int          CLP_ADDR_W      = 4;
    localparam int          CLP_DATA_W      = 5;
    localparam int          CLP_CNT_W       = 8;

    // the configuration clock rate, kept for reference only; no counter uses it
    localparam int          CLP_CLK_HZ      = 50_000_000;

    // channel latch n sits at CLP_ADDR_CH0 + n
    localparam logic [3:0]  CLP_ADDR_CH0    = 4'h0;
    localparam logic [3:0]  CLP_ADDR_CHLAST = 4'h3;

    // field positions inside a channel latch and its readback word
    localparam int          CLP_F_CKSEL     = 0;
    localparam int          CLP_F_RATE      = 1;
    localparam int          CLP_F_HALF      = 2;
    localparam int          CLP_F_RANGE     = 3;

    // values after reset
    localparam logic        CLP_RST_CKSEL   = 1'h1;
    localparam logic        CLP_RST_RATE    = 1'h0;
    localparam logic        CLP_RST_HALF    = 1'h0;
    localparam logic [4:0]  CLP_RST_RDATA   = 5'h00;

    // two-bit encoding of the ternary speed pin
    localparam logic [1:0]  CLP_SPD_LOW     = 2'h0;
    localparam logic [1:0]  CLP_SPD_MID     = 2'h1;
    localparam logic [1:0]  CLP_SPD_HIGH    = 2'h2;

    typedef enum logic [1:0] {
        CLP_RANGE_LOW,
        CLP_RANGE_MID,
        CLP_RANGE_HIGH
    } clp_range_e;

    typedef struct packed {
        logic half_rate;
        logic rate;
        logic cksel;
    } clp_chan_cfg_s;

    localparam clp_chan_cfg_s CLP_RST_CFG = '{half_rate: CLP_RST_HALF,
                                              rate:      CLP_RST_RATE,
                                              cksel:     CLP_RST_CKSEL};

    typedef struct packed {
        logic [CLP_ADDR_W-1:0] addr;
        logic [CLP_DATA_W-1:0] data;
        logic                  strobe;
    } clp_cfg_wr_s;

endpackage : clp_pkg

// ### hdl/clp_txclk_gen.sv
`timescale 1ns/100ps
module clp_txclk_gen
    import clp_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic ref_level_i,
    input  wire logic ref_edge_i,
    input  wire logic rate_i,
    output logic      tx_clk_o,
    output logic      char_tick_o
);

    logic [CLP_CNT_W-1:0] cnt_reg;
    logic [CLP_CNT_W-1:0] mid_reg;
    logic                 tx_clk_next;

    // cycles since the last reference edge; half of it marks the extra toggle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            mid_reg <= '0;
        end else if (ce_i) begin
            if (ref_edge_i) begin
                cnt_reg <= '0;
                mid_reg <= CLP_CNT_W'(({1'b0, cnt_reg} + 1'b1) >> 1);
            end else if (cnt_reg != '1) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // output follows reference edges, so its phase to the reference is
    // only whatever the sampling gives
    always_comb begin
        tx_clk_next = tx_clk_o;
        if (!rate_i) begin
            if (ref_edge_i) begin
                tx_clk_next = ref_level_i;
            end
        end else if (ref_edge_i) begin
            tx_clk_next = ~tx_clk_o;
        end else if (mid_reg != '0 && cnt_reg + 1'b1 == mid_reg) begin
            tx_clk_next = ~tx_clk_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_clk_o    <= 1'b0;
            char_tick_o <= 1'b0;
        end else if (ce_i) begin
            tx_clk_o    <= tx_clk_next;
            char_tick_o <= tx_clk_next & ~tx_clk_o;
        end
    end

endmodule : clp_txclk_gen
